// ==== logic/ppm_port.sv ====
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ppm_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pullup_en,
    input wire logic sleep_clamp,
    input wire logic [7:0] ext_int_en,
    input wire logic [7:0] ext_int_edge_mode,
    output logic [7:0] ext_int_flag_set,
    input wire logic [7:0] pullup_override_en,
    input wire logic [7:0] pullup_override_val,
    input wire logic [7:0] dir_override_en,
    input wire logic [7:0] dir_override_val,
    input wire logic [7:0] outval_override_en,
    input wire logic [7:0] outval_override_val,
    input wire logic [7:0] toggle_override_en,
    input wire logic [7:0] inen_override_en,
    input wire logic [7:0] inen_override_val,
    output logic [7:0] alt_func_input,
    output logic [7:0] pin_change_src,
    output logic timer_osc_out_en
);
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] latch;
        logic [3:0] ctrl;
        logic [7:0] in_s1;
        logic [7:0] in_s2;
        logic [7:0] raw_s1;
        logic [7:0] raw_s2;
        logic sleep_prev;
        logic [7:0] flag;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic osc;
    } ppm_state_t;

    ppm_state_t s_q;
    ppm_state_t s_d;

    logic [7:0] pu_eff;
    logic [7:0] oe_eff;
    logic [7:0] val_eff;
    logic [7:0] inen_eff;
    logic [7:0] schmitt;
    logic [7:0] io_mask;
    logic clk_pin;
    logic osc_out;
    logic access;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bit 7 clock takeover
    assign osc_out = s_q.ctrl[ppm_pkg::CTRL_AS_BIT] & ~s_q.ctrl[ppm_pkg::CTRL_EXT_CLOCK_IN_SEL_BIT];
    assign clk_pin = s_q.ctrl[ppm_pkg::CTRL_XTAL_BIT] | osc_out;
    assign io_mask = {~clk_pin, 7'h7f};

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin override logic
    for (genvar n = 0; n < ppm_pkg::PINS; n++)
    begin : g_pin
        always_comb
        begin
            pu_eff[n] = pullup_override_en[n] ? pullup_override_val[n]
                : ({s_q.dir[n], s_q.latch[n], s_q.ctrl[ppm_pkg::CTRL_PUD_BIT]} == 3'b010);
            oe_eff[n] = dir_override_en[n] ? dir_override_val[n] : s_q.dir[n];
            val_eff[n] = outval_override_en[n] ? outval_override_val[n] : s_q.latch[n];
            inen_eff[n] = inen_override_en[n] ? inen_override_val[n]
                : ~(sleep_clamp & ~ext_int_en[n]);
        end
    end

    // Outputs below are combinational so overrides act at once
    assign pad_oe = {8{presetn}} & oe_eff & io_mask;
    assign pad_out = val_eff & io_mask;
    assign pad_pullup_en = {8{presetn}} & pu_eff & io_mask;
    assign schmitt = pad_in & inen_eff & io_mask;
    assign alt_func_input = schmitt;
    assign access = psel & penable & ~s_q.ready;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        s_d = s_q;
        s_d.in_s1 = schmitt;
        s_d.in_s2 = s_q.in_s1;
        s_d.raw_s1 = pad_in;
        s_d.raw_s2 = s_q.raw_s1;
        s_d.sleep_prev = sleep_clamp;
        s_d.osc = osc_out;
        s_d.ready = access;
        s_d.err = 1'b0;
        s_d.rdata = 32'h0000_0000;
        s_d.flag = {8{s_q.sleep_prev & ~sleep_clamp}} & s_q.raw_s2
            & ext_int_edge_mode & ~ext_int_en;
        if (access & pwrite)
        begin
            if (hit(paddr, ppm_pkg::OFF_DIR))
                s_d.dir = pwdata[7:0];
            else if (hit(paddr, ppm_pkg::OFF_LATCH))
                s_d.latch = pwdata[7:0];
            else if (hit(paddr, ppm_pkg::OFF_INPUT))
                s_d.latch = s_q.latch ^ pwdata[7:0];
            else if (hit(paddr, ppm_pkg::OFF_CTRL))
                s_d.ctrl = pwdata[ppm_pkg::CTRL_W-1:0];
            else
                s_d.err = 1'b1;
        end
        else if (access)
        begin
            if (hit(paddr, ppm_pkg::OFF_DIR))
                s_d.rdata = {24'h000000, s_q.dir & io_mask};
            else if (hit(paddr, ppm_pkg::OFF_LATCH))
                s_d.rdata = {24'h000000, s_q.latch & io_mask};
            else if (hit(paddr, ppm_pkg::OFF_INPUT))
                s_d.rdata = {24'h000000, s_q.in_s2 & io_mask};
            else if (hit(paddr, ppm_pkg::OFF_CTRL))
                s_d.rdata = {28'h0000000, s_q.ctrl};
            else
                s_d.err = 1'b1;
        end
        s_d.latch = s_d.latch ^ toggle_override_en;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.dir <= ppm_pkg::DIR_RST;
            s_q.latch <= ppm_pkg::LATCH_RST;
            s_q.ctrl <= ppm_pkg::CTRL_RST;
        end
        else
            s_q <= s_d;
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign ext_int_flag_set = s_q.flag;
    assign pin_change_src = s_q.in_s2;
    assign timer_osc_out_en = s_q.osc;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_clamp;
        sleep_clamp & ~ext_int_en[3] & ~inen_override_en[3] |-> ~alt_func_input[3];
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamped pin input not low");

    property p_int_escape;
        ext_int_en[0] & ~inen_override_en[0] & pad_in[0] |-> alt_func_input[0];
    endproperty
    a_int_escape: assert property (p_int_escape) else $error("interrupt pin was clamped");

    property p_wake_flag;
        $fell(sleep_clamp) & s_q.raw_s2[1] & ext_int_edge_mode[1] & ~ext_int_en[1] |=> ext_int_flag_set[1];
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake flag missing");

    property p_pullup;
        ~pullup_override_en[3] & ~clk_pin |->
            pad_pullup_en[3] == (~s_q.dir[3] & s_q.latch[3] & ~s_q.ctrl[ppm_pkg::CTRL_PUD_BIT]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up mismatch");

    property p_dir_ovr;
        dir_override_en[4] |-> pad_oe[4] == dir_override_val[4];
    endproperty
    a_dir_ovr: assert property (p_dir_ovr) else $error("direction override ignored");

    property p_val;
        pad_out[5] == (outval_override_en[5] ? outval_override_val[5] : s_q.latch[5]);
    endproperty
    a_val: assert property (p_val) else $error("driven value wrong");

    property p_toggle;
        toggle_override_en[4] & ~(psel & penable & pwrite) |=> s_q.latch[4] != $past(s_q.latch[4]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle failed");

    property p_clk_read;
        clk_pin & psel & penable & ~pwrite & ~pready |=> ~prdata[7];
    endproperty
    a_clk_read: assert property (p_clk_read) else $error("clock pin read nonzero");

    property p_clk_pin_off;
        clk_pin |-> ~pad_oe[7] & ~pad_pullup_en[7];
    endproperty
    a_clk_pin_off: assert property (p_clk_pin_off) else $error("clock pin still general I/O");

    property p_pin_toggle_wr;
        psel & penable & pwrite & ~pready & (paddr == ppm_pkg::OFF_INPUT) & pwdata[0] & ~toggle_override_en[0]
            |=> s_q.latch[0] != $past(s_q.latch[0]);
    endproperty
    a_pin_toggle_wr: assert property (p_pin_toggle_wr) else $error("input write did not toggle");

    property p_pc_src;
        presetn & $past(presetn) & $past(presetn, 2) |-> pin_change_src == $past(schmitt, 2);
    endproperty
    a_pc_src: assert property (p_pc_src) else $error("pin change source lag wrong");

    property p_dir_follow;
        ~dir_override_en[0] |-> pad_oe[0] == s_q.dir[0];
    endproperty
    a_dir_follow: assert property (p_dir_follow) else $error("driver enable not from direction bit");

    property p_dir_write;
        psel & penable & pwrite & ~pready & (paddr == ppm_pkg::OFF_DIR) & ~dir_override_en[1]
            |=> dir_override_en[1] | (pad_oe[1] == $past(pwdata[1]));
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write not applied");

    property p_pu_disable;
        s_q.ctrl[ppm_pkg::CTRL_PUD_BIT] & ~pullup_override_en[6] |-> ~pad_pullup_en[6];
    endproperty
    a_pu_disable: assert property (p_pu_disable) else $error("pull-up on while globally disabled");

    property p_val_ovr;
        outval_override_en[3] |-> pad_out[3] == outval_override_val[3];
    endproperty
    a_val_ovr: assert property (p_val_ovr) else $error("value override ignored");

    property p_pu_ovr;
        pullup_override_en[2] |-> pad_pullup_en[2] == pullup_override_val[2];
    endproperty
    a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up override ignored");

    property p_cmp_out;
        pad_oe[1] & outval_override_en[1] |-> pad_out[1] == outval_override_val[1];
    endproperty
    a_cmp_out: assert property (p_cmp_out) else $error("compare output not on pin");

    property p_rst_tristate;
        disable iff (1'b0) !presetn |-> pad_oe == 8'h00;
    endproperty
    a_rst_tristate: assert property (p_rst_tristate) else $error("pin driven in reset");

    property p_rst_pullup;
        disable iff (1'b0) !presetn |-> pad_pullup_en == 8'h00;
    endproperty
    a_rst_pullup: assert property (p_rst_pullup) else $error("pull-up on in reset");

    property p_escape_all;
        sleep_clamp |-> (alt_func_input & ext_int_en & ~inen_override_en & io_mask)
            == (pad_in & ext_int_en & ~inen_override_en & io_mask);
    endproperty
    a_escape_all: assert property (p_escape_all) else $error("interrupt pins clamped");

    property p_clamp_all;
        sleep_clamp |-> (alt_func_input & ~ext_int_en & ~inen_override_en) == 8'h00;
    endproperty
    a_clamp_all: assert property (p_clamp_all) else $error("sleeping input not clamped");

    property p_inen_ovr;
        inen_override_en[2] |-> alt_func_input[2] == (inen_override_val[2] & pad_in[2]);
    endproperty
    a_inen_ovr: assert property (p_inen_ovr) else $error("input enable override ignored");

    property p_inen_awake;
        ~inen_override_en[5] & ~sleep_clamp |-> alt_func_input[5] == pad_in[5];
    endproperty
    a_inen_awake: assert property (p_inen_awake) else $error("awake input disabled");

    property p_alt_raw;
        ~sleep_clamp & (inen_override_en == 8'h00) & ~clk_pin |-> alt_func_input == pad_in;
    endproperty
    a_alt_raw: assert property (p_alt_raw) else $error("alternate input delayed");

    property p_toggle_hold;
        ~toggle_override_en[4] & ~(psel & penable) |=> s_q.latch[4] == $past(s_q.latch[4]);
    endproperty
    a_toggle_hold: assert property (p_toggle_hold) else $error("latch changed without cause");

    property p_flag_wake_only;
        ~($past(sleep_clamp, 2) & ~$past(sleep_clamp)) |-> ext_int_flag_set == 8'h00;
    endproperty
    a_flag_wake_only: assert property (p_flag_wake_only) else $error("flag set outside wake");

    property p_flag_disabled;
        (ext_int_flag_set & $past(ext_int_en)) == 8'h00;
    endproperty
    a_flag_disabled: assert property (p_flag_disabled) else $error("flag set for enabled interrupt");

    property p_osc_sel;
        1 |=> timer_osc_out_en == ($past(s_q.ctrl[ppm_pkg::CTRL_AS_BIT]) & ~$past(s_q.ctrl[ppm_pkg::CTRL_EXT_CLOCK_IN_SEL_BIT]));
    endproperty
    a_osc_sel: assert property (p_osc_sel) else $error("oscillator output select wrong");

    property p_osc_pin;
        osc_out |-> ~pad_oe[7] & ~pad_out[7];
    endproperty
    a_osc_pin: assert property (p_osc_pin) else $error("oscillator pin still driven");

    property p_clk_pin_quiet;
        clk_pin |-> ~alt_func_input[7] & ~pad_out[7];
    endproperty
    a_clk_pin_quiet: assert property (p_clk_pin_quiet) else $error("clock pin still in port path");

    property p_ready_pulse;
        pready |=> ~pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");

    property p_rdata_idle;
        ~pready |-> prdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

    property p_unmapped;
        psel & penable & ~pready & (paddr[11:4] != 8'h00) |=> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");

    property p_in_read;
        ~clk_pin & psel & penable & ~pwrite & ~pready & (paddr == ppm_pkg::OFF_INPUT)
            |=> prdata[7:0] == $past(pin_change_src);
    endproperty
    a_in_read: assert property (p_in_read) else $error("input read not synchronised levels");
endmodule
`default_nettype wire

// ==== logic/ppm_pkg.sv ====
`default_nettype none
package ppm_pkg;
    localparam int PINS = 8;
    localparam logic [11:0] OFF_DIR = 12'h000;
    localparam logic [11:0] OFF_LATCH = 12'h004;
    localparam logic [11:0] OFF_INPUT = 12'h008;
    localparam logic [11:0] OFF_CTRL = 12'h00c;
    localparam int CTRL_PUD_BIT = 0;
    localparam int CTRL_AS_BIT = 1;
    localparam int CTRL_EXT_CLOCK_IN_SEL_BIT = 2;
    localparam int CTRL_XTAL_BIT = 3;
    localparam int CTRL_W = 4;
    localparam int CLK_PIN = 7;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [3:0] CTRL_RST = 4'h0;
endpackage
`default_nettype wire

// ==== dv/ppm_periph.sv ====
`timescale 1ns/100ps
`default_nettype none
module ppm_periph (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [8:0][7:0] req,
    output logic [7:0] pullup_override_en,
    output logic [7:0] pullup_override_val,
    output logic [7:0] dir_override_en,
    output logic [7:0] dir_override_val,
    output logic [7:0] outval_override_en,
    output logic [7:0] outval_override_val,
    output logic [7:0] toggle_override_en,
    output logic [7:0] inen_override_en,
    output logic [7:0] inen_override_val
);
    logic [8:0][7:0] ovr_q;
    logic [7:0] tog_q;
    // Each function owns its own override pair, except toggle, which has only an enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovr_q <= '0;
            tog_q <= '0;
        end
        else
        begin
            ovr_q <= req;
            ovr_q[6] <= req[6] & ~tog_q;
            tog_q <= req[6];
        end
    end
    assign pullup_override_en = ovr_q[0];
    assign pullup_override_val = ovr_q[1];
    assign dir_override_en = ovr_q[2];
    assign dir_override_val = ovr_q[3];
    assign outval_override_en = ovr_q[4];
    assign outval_override_val = ovr_q[5];
    assign toggle_override_en = ovr_q[6];
    assign inen_override_en = ovr_q[7];
    assign inen_override_val = ovr_q[8];
endmodule
`default_nettype wire

// ==== dv/port_pin_override_mux_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, x) begin checks++; if ((a) !== (x)) begin failures++; $display("unexpected %0t %h", $time, a); end end
module port_pin_override_mux_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sc = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [7:0] ext = 8'hff, ie = '0, em = '0, acc, pad_out, pad_oe, pu, fl, alt, pcs;
    logic [8:0][7:0] req = '0;
    logic pready, pslverr, tosc, e;
    logic [31:0] r;
    wire logic [8:0][7:0] ov;
    // Pin level from our drive or the outside world
    wire logic [7:0] pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
    int checks = 0, failures = 0, cyc_n = 0;
    always #12.5 pclk = ~pclk;
    ppm_periph u_per (.pclk(pclk), .presetn(presetn), .req(req), .pullup_override_en(ov[0]),
        .pullup_override_val(ov[1]), .dir_override_en(ov[2]), .dir_override_val(ov[3]),
        .outval_override_en(ov[4]), .outval_override_val(ov[5]), .toggle_override_en(ov[6]),
        .inen_override_en(ov[7]), .inen_override_val(ov[8]));
    ppm_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pu), .sleep_clamp(sc),
        .ext_int_en(ie), .ext_int_edge_mode(em), .ext_int_flag_set(fl), .pullup_override_en(ov[0]),
        .pullup_override_val(ov[1]), .dir_override_en(ov[2]), .dir_override_val(ov[3]),
        .outval_override_en(ov[4]), .outval_override_val(ov[5]), .toggle_override_en(ov[6]),
        .inen_override_en(ov[7]), .inen_override_val(ov[8]), .alt_func_input(alt),
        .pin_change_src(pcs), .timer_osc_out_en(tosc));
    task complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rdc(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h0);
        `CHK(r, {24'h0, x})
        `CHK(e, 1'b0)
    endtask
    task cy(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    always @(posedge pclk)
    begin
        cyc_n++;
        if (cyc_n > 3000)
        begin
            failures++;
            complete_run();
        end
    end
    initial
    begin
        cy(15);
        `CHK(pad_oe | pu, 8'h00)
        @(posedge pclk);
        presetn <= 1;
        apb(1'b1, ppm_pkg::OFF_DIR, 8'h0f);
        apb(1'b1, ppm_pkg::OFF_LATCH, 8'hf3);
        cy(1);
        `CHK(pad_oe, 8'h0f)
        `CHK(pad_out & pad_oe, 8'h03)
        `CHK(pu, 8'hf0)
        apb(1'b1, ppm_pkg::OFF_CTRL, 8'h01);
        cy(1);
        `CHK(pu, 8'h00)
        apb(1'b1, ppm_pkg::OFF_CTRL, 8'h00);
        apb(1'b1, ppm_pkg::OFF_INPUT, 8'h81);
        rdc(ppm_pkg::OFF_LATCH, 8'h72);
        @(posedge pclk);
        presetn <= 0;
        #1;
        `CHK({pad_oe, pu}, 16'h0)
        @(posedge pclk);
        presetn <= 1;
        rdc(ppm_pkg::OFF_LATCH, 8'h00);
        @(posedge pclk);
        req[0] <= 8'hff;
        req[1] <= 8'h55;
        req[2] <= 8'hff;
        req[3] <= 8'haa;
        req[4] <= 8'hff;
        req[5] <= 8'h3c;
        cy(2);
        `CHK(pu, 8'h55)
        `CHK(pad_oe, 8'haa)
        `CHK(pad_out & pad_oe, 8'h28)
        @(posedge pclk);
        req <= 72'h00_00_11_00_00_00_00_00_00;
        cy(4);
        rdc(ppm_pkg::OFF_LATCH, 8'h11);
        @(posedge pclk);
        req[6] <= 8'h00;
        sc <= 1;
        ie <= 8'h01;
        em <= 8'h02;
        req[7] <= 8'h06;
        req[8] <= 8'h02;
        cy(4);
        `CHK(alt, 8'h03)
        @(posedge pclk);
        sc <= 0;
        acc = 0;
        repeat (6)
        begin
            @(posedge pclk);
            #1;
            acc |= fl;
        end
        `CHK(acc, 8'h02)
        `CHK(alt, 8'hfb)
        `CHK(pcs, 8'hfb)
        apb(1'b1, ppm_pkg::OFF_DIR, 8'h80);
        apb(1'b1, ppm_pkg::OFF_LATCH, 8'h91);
        apb(1'b1, ppm_pkg::OFF_CTRL, 8'h08);
        cy(4);
        `CHK({pad_oe[7], pu[7]}, 2'b00)
        rdc(ppm_pkg::OFF_DIR, 8'h00);
        rdc(ppm_pkg::OFF_LATCH, 8'h11);
        rdc(ppm_pkg::OFF_INPUT, 8'h7b);
        apb(1'b1, ppm_pkg::OFF_CTRL, 8'h02);
        cy(2);
        `CHK(tosc, 1'b1)
        apb(1'b1, ppm_pkg::OFF_CTRL, 8'h06);
        cy(2);
        `CHK(tosc, 1'b0)
        apb(1'b0, 12'h010, 8'h0);
        `CHK({e, r}, {1'b1, 32'h0})
        complete_run();
    end
endmodule
`default_nettype wire
